// *** rtl/bmpm_defs.vh ***
// constants for the battery monitor power-mode sequencer
`ifndef BMPM_DEFS_VH
`define BMPM_DEFS_VH

// clock and timebase
`define BMPM_CLK_MHZ 125
`define BMPM_TICK_US 1000
`define BMPM_SEC_MS 1000
`define BMPM_RST_LONG_MS 10'd1000

// measurement schedule, in ms ticks, loop counts and seconds
`define BMPM_CUR_MS 2'd3
`define BMPM_VOLT_MIN 8'd10
`define BMPM_SLEEP_SAMP_MS 4'd12
`define BMPM_DS_WAKE_MS 9'd250
`define BMPM_DS_LOOP_MS 9'd30
`define BMPM_MIN_SEC 6'd60

// register byte offsets
`define BMPM_REG_CMD 8'h00
`define BMPM_REG_CFG 8'h04
`define BMPM_REG_THR 8'h08
`define BMPM_REG_TIM0 8'h0c
`define BMPM_REG_TIM1 8'h10
`define BMPM_REG_STAT 8'h14

// command bits
`define BMPM_CMD_ALLOW 0
`define BMPM_CMD_DISALLOW 1
`define BMPM_CMD_DEEP 2
`define BMPM_CMD_EXIT 3
`define BMPM_CMD_SHUT 4
`define BMPM_CMD_WAKE 5

// configuration bits
`define BMPM_CFG_AUXKEEP 0
`define BMPM_CFG_STACKSD 1
`define BMPM_CFG_CELLSD 2
`define BMPM_CFG_TEMPSD 3
`define BMPM_CFG_DIEOT 4
`define BMPM_CFG_ICMASK 12:8

// reset values
`define BMPM_CFG_RST 32'h0000_0000
`define BMPM_THR_RST 32'h0040_0010
`define BMPM_TIM0_RST 32'h0a05_0205
`define BMPM_TIM1_RST 32'h0000_0a05

// bus answers
`define BMPM_RESP_OKAY 2'h0
`define BMPM_RESP_SLVERR 2'h2

// power modes as reported
`define BMPM_MODE_NORMAL 2'h0
`define BMPM_MODE_SLEEP 2'h1
`define BMPM_MODE_DEEP 2'h2
`define BMPM_MODE_SHUT 2'h3

`endif

// *** rtl/bmpm_timebase.v ***
// slow-oscillator timebase: millisecond and one-second ticks
`timescale 1ns/1ps
`include "bmpm_defs.vh"

module bmpm_timebase #(
	parameter MS_CYCLES = `BMPM_TICK_US * `BMPM_CLK_MHZ
) (
	// clock and reset
	input wire mclk,
	input wire rst_s_n,
	// ticks
	output reg ms_tick,
	output reg sec_tick
);

reg [16:0] div;
reg [9:0] ms_cnt;

always @(posedge mclk or negedge rst_s_n) begin
	if (!rst_s_n) begin
		div <= 17'h0;
		ms_cnt <= 10'h0;
		ms_tick <= 1'b0;
		sec_tick <= 1'b0;
	end else begin
		ms_tick <= 1'b0;
		sec_tick <= 1'b0;
		if (div == MS_CYCLES[16:0] - 17'h1) begin
			div <= 17'h0;
			ms_tick <= 1'b1;
			// the second tick always lands on a millisecond tick
			if (ms_cnt == `BMPM_SEC_MS - 10'h1) begin
				ms_cnt <= 10'h0;
				sec_tick <= 1'b1;
			end else begin
				ms_cnt <= ms_cnt + 10'h1;
			end
		end else begin
			div <= div + 17'h1;
		end
	end
end

endmodule

// *** rtl/bmpm_top.v ***
// power-mode sequencer of a battery monitor with an axi4-lite slave
`timescale 1ns/1ps
`include "bmpm_defs.vh"

module bmpm_top #(
	parameter MS_CYCLES = `BMPM_TICK_US * `BMPM_CLK_MHZ
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// axi4-lite write
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// pins and analog comparators
	input wire rst_shut_pin,
	input wire wake_sense_pin,
	input wire load_detect_above_wake,
	input wire battery_below_por,
	input wire prot_fault,
	input wire charger_detect,
	input wire stack_below_sd,
	input wire [4:0] cell_below_sd,
	input wire int_temp_high,
	input wire die_overtemp,
	input wire mem_error,
	input wire pack_above_stack_delta,
	input wire stack_below_pack_thr,
	// filter magnitudes
	input wire [15:0] accumulating_current_filter,
	input wire [15:0] fast_current_filter,
	// protection requests and boot memory
	input wire [3:0] switch_request,
	input wire otp_written,
	input wire otp_sleep_en,
	input wire otp_storage_en,
	input wire [7:0] otp_storage_min,
	// mode and measurement control
	output reg [1:0] mode,
	output reg meas_current,
	output reg meas_voltage,
	output reg meas_temp,
	output reg sleep_current_sample,
	output reg comparator_prot_en,
	output reg adc_prot_en,
	output reg slow_oscillator_fast,
	output reg auxiliary_regulator_en,
	output reg power_down,
	output reg boot_load_otp,
	output reg boot_defaults,
	output reg watchdog_reset,
	output reg digital_reset,
	// protection switches
	output wire charge_switch,
	output wire precharge_switch,
	output wire discharge_switch,
	output wire predischarge_switch
);

localparam ST_NORMAL = 3'd0;
localparam ST_SLEEP = 3'd1;
localparam ST_DEEP = 3'd2;
localparam ST_SHUT = 3'd3;
localparam ST_DSEXIT = 3'd4;
localparam ST_SDSEQ = 3'd5;
localparam ST_BOOT = 3'd6;

reg rst_m, rst_s_n;
wire ms_tick, sec_tick;
reg [2:0] state;
reg [31:0] cfg, thr, tim0, tim1;
reg sleep_allowed, data_fresh, loop_hold, sw_off;
reg p_allow, p_dis, p_deep, p_exit, p_sd, p_wake;
reg rst_long, rst_short, rst_d;
reg [9:0] rst_ms;
reg [1:0] c3;
reg [7:0] vcnt, ivl_s, hyst_s, sd_s, temp_s, mem_s, stor_min;
reg [3:0] c12;
reg [8:0] dx_ms;
reg [5:0] stor_sec;
reg hyst_run, mem_win, stor_arm, ld_d;
reg [3:0] sw;
reg [31:0] rd_val;

//------------------------------------------------------------
// reset release and timebase
//------------------------------------------------------------
always @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		rst_m <= 1'b0;
		rst_s_n <= 1'b0;
	end else begin
		rst_m <= 1'b1;
		rst_s_n <= rst_m;
	end
end

bmpm_timebase #(.MS_CYCLES(MS_CYCLES)) u_tb (
	.mclk(mclk),
	.rst_s_n(rst_s_n),
	.ms_tick(ms_tick),
	.sec_tick(sec_tick)
);

//------------------------------------------------------------
// register bus
//------------------------------------------------------------
function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] be;
	integer b;
	begin
		merge = old;
		for (b = 0; b < 4; b = b + 1)
			if (be[b])
				merge[b*8 +: 8] = nw[b*8 +: 8];
	end
endfunction

wire in_shut = (state == ST_SHUT);
wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
wire wr_ok = wr_go & ~in_shut;
wire cmd_wr = wr_ok & (s_axi_awaddr == `BMPM_REG_CMD) & s_axi_wstrb[0];
wire [7:0] cmd = cmd_wr ? s_axi_wdata[7:0] : 8'h00;
wire wr_hit = (s_axi_awaddr == `BMPM_REG_CMD) |
	(s_axi_awaddr == `BMPM_REG_CFG) | (s_axi_awaddr == `BMPM_REG_THR) |
	(s_axi_awaddr == `BMPM_REG_TIM0) | (s_axi_awaddr == `BMPM_REG_TIM1);

assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign s_axi_arready = rd_go;

always @(posedge mclk or negedge rst_s_n) begin
	if (!rst_s_n) begin
		cfg <= `BMPM_CFG_RST;
		thr <= `BMPM_THR_RST;
		tim0 <= `BMPM_TIM0_RST;
		tim1 <= `BMPM_TIM1_RST;
	end else if (in_shut) begin
		cfg <= `BMPM_CFG_RST;
		thr <= `BMPM_THR_RST;
		tim0 <= `BMPM_TIM0_RST;
		tim1 <= `BMPM_TIM1_RST;
	end else if (wr_ok) begin
		case (s_axi_awaddr)
		`BMPM_REG_CFG: cfg <= merge(cfg, s_axi_wdata, s_axi_wstrb);
		`BMPM_REG_THR: thr <= merge(thr, s_axi_wdata, s_axi_wstrb);
		`BMPM_REG_TIM0: tim0 <= merge(tim0, s_axi_wdata, s_axi_wstrb);
		`BMPM_REG_TIM1: tim1 <= merge(tim1, s_axi_wdata, s_axi_wstrb);
		default: ;
		endcase
	end
end

always @* begin
	case (s_axi_araddr)
	`BMPM_REG_CMD: rd_val = 32'h0;
	`BMPM_REG_CFG: rd_val = cfg;
	`BMPM_REG_THR: rd_val = thr;
	`BMPM_REG_TIM0: rd_val = tim0;
	`BMPM_REG_TIM1: rd_val = tim1;
	`BMPM_REG_STAT: rd_val = {20'h0, sw, 2'h0, (state == ST_SDSEQ),
		data_fresh, (state == ST_SLEEP), sleep_allowed, mode};
	default: rd_val = 32'h0;
	endcase
end

always @(posedge mclk or negedge rst_s_n) begin
	if (!rst_s_n) begin
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `BMPM_RESP_OKAY;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= `BMPM_RESP_OKAY;
		s_axi_rdata <= 32'h0;
	end else begin
		if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_hit & ~in_shut) ? `BMPM_RESP_OKAY :
				`BMPM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= in_shut ? 32'h0 : rd_val;
			s_axi_rresp <= (in_shut | (s_axi_araddr > `BMPM_REG_STAT) |
				(s_axi_araddr[1:0] != 2'h0)) ?
				`BMPM_RESP_SLVERR : `BMPM_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

//------------------------------------------------------------
// condition decode
//------------------------------------------------------------
wire [15:0] relax_thr = thr[15:0];
wire [15:0] wake_thr = thr[31:16];
wire cell_low = |(cell_below_sd & ~cfg[`BMPM_CFG_ICMASK]);
wire active = (state == ST_NORMAL) | (state == ST_SLEEP);
wire temp_fire = cfg[`BMPM_CFG_TEMPSD] & (temp_s >= tim0[23:16]) &
	int_temp_high & active;
wire stor_fire = stor_arm & (stor_min >= otp_storage_min);
wire mem_shut = mem_error & mem_win;
wire sd_req = p_sd | rst_long | temp_fire | stor_fire | mem_shut |
	(cfg[`BMPM_CFG_STACKSD] & stack_below_sd) |
	(cfg[`BMPM_CFG_CELLSD] & cell_low) |
	(cfg[`BMPM_CFG_DIEOT] & die_overtemp);
wire volt_due = (vcnt + 8'h1 >= ((tim1[15:8] < `BMPM_VOLT_MIN) ?
	`BMPM_VOLT_MIN : tim1[15:8]));
wire sched = (state == ST_NORMAL) | (state == ST_DSEXIT);

//------------------------------------------------------------
// reset/shutdown pin timing
//------------------------------------------------------------
always @(posedge mclk or negedge rst_s_n) begin
	if (!rst_s_n) begin
		rst_ms <= 10'h0;
		rst_long <= 1'b0;
		rst_short <= 1'b0;
		rst_d <= 1'b0;
		digital_reset <= 1'b0;
	end else begin
		rst_d <= rst_shut_pin;
		digital_reset <= rst_shut_pin;
		if (!rst_shut_pin) begin
			rst_ms <= 10'h0;
			rst_long <= 1'b0;
		end else if (ms_tick & ~rst_long) begin
			rst_ms <= rst_ms + 10'h1;
			rst_long <= (rst_ms + 10'h1 >= `BMPM_RST_LONG_MS);
		end
		// a release before the long limit is a short press, kept to a tick
		if (rst_d & ~rst_shut_pin & ~rst_long)
			rst_short <= 1'b1;
		else if (ms_tick)
			rst_short <= 1'b0;
	end
end

//------------------------------------------------------------
// mode sequencer
//------------------------------------------------------------
always @(posedge mclk or negedge rst_s_n) begin
	if (!rst_s_n) begin
		state <= ST_BOOT;
		sleep_allowed <= 1'b0;
		{p_allow, p_dis, p_deep, p_exit, p_sd, p_wake} <= 6'h0;
		{data_fresh, loop_hold, sw_off, hyst_run} <= 4'h0;
		{mem_win, stor_arm, ld_d, watchdog_reset} <= 4'h0;
		{boot_load_otp, boot_defaults} <= 2'h0;
		{meas_current, meas_voltage, meas_temp} <= 3'h0;
		sleep_current_sample <= 1'b0;
		c3 <= 2'h0;
		c12 <= 4'h0;
		dx_ms <= 9'h0;
		stor_sec <= 6'h0;
		{vcnt, ivl_s, hyst_s, sd_s, temp_s, mem_s, stor_min} <= 56'h0;
	end else begin
		{meas_current, meas_voltage, meas_temp} <= 3'h0;
		sleep_current_sample <= 1'b0;
		{boot_load_otp, boot_defaults, watchdog_reset} <= 3'h0;
		// commands wait for the next tick; a new one beats the consume
		p_allow <= (p_allow & ~ms_tick) | cmd[`BMPM_CMD_ALLOW];
		p_dis <= (p_dis & ~ms_tick) | cmd[`BMPM_CMD_DISALLOW];
		p_deep <= (p_deep & ~ms_tick) | cmd[`BMPM_CMD_DEEP];
		p_exit <= (p_exit & ~ms_tick) | cmd[`BMPM_CMD_EXIT];
		p_sd <= (p_sd & ~ms_tick) | cmd[`BMPM_CMD_SHUT];
		p_wake <= (p_wake & ~ms_tick) | cmd[`BMPM_CMD_WAKE];
		if (cmd_wr)
			stor_arm <= 1'b0; // a command write marks the wake intended
		if (ms_tick) begin
			ld_d <= load_detect_above_wake;
			c3 <= (c3 == `BMPM_CUR_MS - 2'h1) ? 2'h0 : c3 + 2'h1;
			c12 <= (c12 == `BMPM_SLEEP_SAMP_MS - 4'h1) ? 4'h0 : c12 + 4'h1;
			if (sec_tick) begin
				loop_hold <= 1'b0;
				if (hyst_run) begin
					hyst_s <= hyst_s + 8'h1;
					hyst_run <= (hyst_s + 8'h1 < tim0[7:0]);
				end
				if (int_temp_high & active)
					temp_s <= temp_s + ((temp_s == 8'hff) ? 8'h0 : 8'h1);
				if (mem_win) begin
					mem_s <= mem_s + 8'h1;
					mem_win <= (mem_s + 8'h1 < tim0[31:24]);
				end
				if (stor_arm) begin
					stor_sec <= (stor_sec == `BMPM_MIN_SEC - 6'h1) ?
						6'h0 : stor_sec + 6'h1;
					if (stor_sec == `BMPM_MIN_SEC - 6'h1)
						stor_min <= stor_min + 8'h1;
				end
			end
			if (!(int_temp_high & active))
				temp_s <= 8'h0;
			if (mem_error & ~mem_win) begin
				watchdog_reset <= 1'b1;
				mem_win <= 1'b1;
				mem_s <= 8'h0;
			end
			if (state != ST_DEEP && state != ST_SHUT) begin
				if (p_allow) sleep_allowed <= 1'b1;
				if (p_dis) sleep_allowed <= 1'b0;
			end
			// full-rate measurement loop
			if (sched & ~loop_hold & (c3 == 2'h0)) begin
				meas_current <= 1'b1;
				data_fresh <= 1'b1;
				vcnt <= volt_due ? 8'h0 : vcnt + 8'h1;
				meas_voltage <= volt_due;
				meas_temp <= volt_due;
			end
			case (state)
			ST_BOOT: begin
				boot_load_otp <= otp_written;
				boot_defaults <= ~otp_written;
				sleep_allowed <= otp_sleep_en;
				stor_arm <= otp_storage_en;
				{stor_sec, stor_min} <= 14'h0;
				{sw_off, hyst_run, data_fresh} <= 3'h0;
				state <= ST_NORMAL;
			end
			ST_NORMAL: begin
				if (sd_req) begin
					state <= ST_SDSEQ;
					sd_s <= 8'h0;
				end else if (p_deep) begin
					state <= ST_DEEP;
					data_fresh <= 1'b0;
				end else if ((accumulating_current_filter < relax_thr) &
					sleep_allowed & ~hyst_run) begin
					state <= ST_SLEEP;
					ivl_s <= 8'h0;
				end
			end
			ST_SLEEP: begin
				if (c12 == 4'h0)
					sleep_current_sample <= 1'b1;
				if (sec_tick) begin
					ivl_s <= (ivl_s + 8'h1 >= tim1[7:0]) ? 8'h0 : ivl_s + 8'h1;
					if (ivl_s + 8'h1 >= tim1[7:0]) begin
						{meas_current, meas_voltage, meas_temp} <= 3'h7;
						data_fresh <= 1'b1;
					end
				end
				if (sd_req) begin
					state <= ST_SDSEQ;
					sd_s <= 8'h0;
				end else if ((c12 == 4'h0) &
					(fast_current_filter > wake_thr)) begin
					state <= ST_NORMAL;
					loop_hold <= 1'b1;
					hyst_run <= 1'b1;
					hyst_s <= 8'h0;
				end else if (prot_fault | charger_detect | p_wake |
					rst_short | (sec_tick & (ivl_s + 8'h1 >= tim1[7:0]) &
					((accumulating_current_filter > wake_thr) |
					(pack_above_stack_delta & stack_below_pack_thr)))) begin
					state <= ST_NORMAL;
					hyst_run <= 1'b1;
					hyst_s <= 8'h0;
				end
			end
			ST_DEEP: begin
				data_fresh <= 1'b0;
				if (battery_below_por)
					state <= ST_SHUT;
				else if (rst_long) begin
					state <= ST_SDSEQ;
					sd_s <= 8'h0;
				end else if (p_exit | rst_short |
					(load_detect_above_wake & ~ld_d)) begin
					state <= ST_DSEXIT;
					dx_ms <= 9'h0;
				end
			end
			ST_DSEXIT: begin
				if (dx_ms < `BMPM_DS_WAKE_MS + `BMPM_DS_LOOP_MS)
					dx_ms <= dx_ms + 9'h1;
				else if (!prot_fault)
					state <= ST_NORMAL;
			end
			ST_SDSEQ: begin
				if (sec_tick & (sd_s < tim0[15:8]))
					sd_s <= sd_s + 8'h1;
				if (sd_s >= tim0[15:8]) begin
					sw_off <= 1'b1;
					if (!load_detect_above_wake)
						state <= ST_SHUT;
				end
			end
			ST_SHUT: begin
				mem_win <= 1'b0;
				sw_off <= 1'b0;
				if (!wake_sense_pin | load_detect_above_wake)
					state <= ST_BOOT;
			end
			default: state <= ST_BOOT;
			endcase
		end
	end
end

//------------------------------------------------------------
// mode outputs and switches
//------------------------------------------------------------
wire sw_allow = ((state == ST_NORMAL) | (state == ST_SLEEP) |
	(state == ST_SDSEQ)) & ~sw_off;

always @(posedge mclk or negedge rst_s_n) begin
	if (!rst_s_n) begin
		mode <= `BMPM_MODE_SHUT;
		comparator_prot_en <= 1'b0;
		adc_prot_en <= 1'b0;
		slow_oscillator_fast <= 1'b0;
		auxiliary_regulator_en <= 1'b0;
		power_down <= 1'b0;
	end else begin
		case (state)
		ST_NORMAL, ST_SDSEQ: mode <= `BMPM_MODE_NORMAL;
		ST_SLEEP: mode <= `BMPM_MODE_SLEEP;
		ST_DEEP, ST_DSEXIT: mode <= `BMPM_MODE_DEEP;
		default: mode <= `BMPM_MODE_SHUT;
		endcase
		comparator_prot_en <= active | (state == ST_SDSEQ);
		adc_prot_en <= sched | active;
		slow_oscillator_fast <= sched | (state == ST_SDSEQ);
		auxiliary_regulator_en <= (state == ST_DEEP) ?
			cfg[`BMPM_CFG_AUXKEEP] : ~in_shut & (state != ST_BOOT);
		power_down <= in_shut;
	end
end

genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_sw
		always @(posedge mclk or negedge rst_s_n) begin
			if (!rst_s_n)
				sw[gi] <= 1'b0;
			else if (!rst_shut_pin | ~sw_allow)
				sw[gi] <= sw_allow & switch_request[gi];
		end
	end
endgenerate

assign charge_switch = sw[0];
assign precharge_switch = sw[1];
assign discharge_switch = sw[2];
assign predischarge_switch = sw[3];

endmodule

// *** verification/bmpm_asserts.sv ***
// port checker for the power-mode sequencer
`timescale 1ns/1ps
module bmpm_asserts #(
	parameter MS_CYCLES = 125000
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// pins and bus answer
	input wire rst_shut_pin,
	input wire load_detect_above_wake,
	input wire otp_written,
	input wire s_axi_rvalid,
	input wire [1:0] s_axi_rresp,
	// mode outputs
	input wire [1:0] mode,
	input wire sleep_current_sample,
	input wire comparator_prot_en,
	input wire power_down,
	input wire boot_defaults,
	input wire charge_switch,
	input wire precharge_switch,
	input wire discharge_switch,
	input wire predischarge_switch
);
	wire [3:0] sw;
	integer gap;
	reg armed;
	assign sw = {predischarge_switch, discharge_switch, precharge_switch,
		charge_switch};
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// spacing is judged only between two samples of one stay in sleep
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gap <= 0;
			armed <= 1'b0;
		end else if (mode != 2'h1) begin
			gap <= 0;
			armed <= 1'b0;
		end else if (sleep_current_sample) begin
			gap <= 1;
			armed <= 1'b1;
		end else begin
			gap <= gap + 1;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_deep_sw_off: assert property (
		mode == 2'h2 && $past(mode) == 2'h2 |-> sw == 4'h0)
		else $error("switch driven in deepsleep");
	chk_shut_sw_off: assert property (
		mode == 2'h3 && $past(mode) == 2'h3 |-> sw == 4'h0)
		else $error("switch driven in shutdown");
	chk_sample_mode: assert property (
		sleep_current_sample |-> mode == 2'h1 || $past(mode) == 2'h1)
		else $error("sleep sample outside sleep");
	chk_sample_gap: assert property (
		sleep_current_sample && armed |-> gap == 12 * MS_CYCLES)
		else $error("sleep sample spacing wrong");
	chk_sleep_comp: assert property (
		mode == 2'h1 && $past(mode) == 2'h1 |-> comparator_prot_en)
		else $error("comparators off in sleep");
	chk_pd_load: assert property (
		$rose(power_down) |-> !load_detect_above_wake)
		else $error("power down with load pin high");
	chk_pd_mode: assert property (
		power_down && $past(power_down) |-> mode == 2'h3)
		else $error("power down outside shutdown");
	chk_shut_refuse: assert property (
		s_axi_rvalid && power_down |-> s_axi_rresp == 2'h2)
		else $error("read answered in shutdown");
	chk_pin_hold: assert property (
		rst_shut_pin && $past(rst_shut_pin) && mode == $past(mode)
		|-> $stable(sw)) else $error("switches moved under reset pin");
	chk_boot_src: assert property (
		boot_defaults |-> !otp_written)
		else $error("defaults loaded with memory written");
	cov_sleep_sample: cover property (sleep_current_sample && armed);
	cov_power_down: cover property ($rose(power_down));
	cov_deep: cover property (mode == 2'h2 && $past(mode) == 2'h0);
endmodule

bind bmpm_top bmpm_asserts #(.MS_CYCLES(MS_CYCLES)) bmpm_asserts_inst (.*);

// *** verification/bmpm_host_model.sv ***
// host model: register bus master issuing mode subcommands
`timescale 1ns/1ps
module bmpm_host_model (
	// clock
	input wire mclk,
	// write channels
	output reg [7:0] s_axi_awaddr,
	output reg s_axi_awvalid,
	input wire s_axi_awready,
	output reg [31:0] s_axi_wdata,
	output reg [3:0] s_axi_wstrb,
	output reg s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	output reg s_axi_bready,
	// read channels
	output reg [7:0] s_axi_araddr,
	output reg s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	output reg s_axi_rready
);
	reg pa, pw, pb;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
		s_axi_wstrb = 4'hf;
	end
	// allow, disallow and deepsleep subcommands all travel through wr
	task wr(input [7:0] a, input [31:0] v, output [1:0] r);
		begin
			@(posedge mclk);
			pa = 1'b1;
			pw = 1'b1;
			pb = 1'b1;
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (pa || pw || pb) begin
				@(posedge mclk);
				if (pb && s_axi_bvalid) begin
					pb = 1'b0;
					s_axi_bready <= 1'b0;
					r = s_axi_bresp;
				end
				// released payload is scrambled, not left at its last value
				if (pa && s_axi_awready) begin
					pa = 1'b0;
					s_axi_awvalid <= 1'b0;
					s_axi_awaddr <= ~a;
				end
				if (pw && s_axi_wready) begin
					pw = 1'b0;
					s_axi_wvalid <= 1'b0;
					s_axi_wdata <= ~v;
				end
			end
		end
	endtask
	task rd(input [7:0] a, output [31:0] v, output [1:0] r);
		begin
			@(posedge mclk);
			pa = 1'b1;
			pb = 1'b1;
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			while (pa || pb) begin
				@(posedge mclk);
				if (pb && s_axi_rvalid) begin
					pb = 1'b0;
					s_axi_rready <= 1'b0;
					v = s_axi_rdata;
					r = s_axi_rresp;
				end
				if (pa && s_axi_arready) begin
					pa = 1'b0;
					s_axi_arvalid <= 1'b0;
					s_axi_araddr <= ~a;
				end
			end
		end
	endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
`include "bmpm_defs.vh"
module tb;
	localparam MS = 5;
	localparam [1:0] OK = `BMPM_RESP_OKAY;
	localparam [1:0] ERR = `BMPM_RESP_SLVERR;
	logic mclk, rst_n, rst_shut_pin, wake_sense_pin, load_detect_above_wake;
	logic battery_below_por, prot_fault, charger_detect, mem_error;
	logic pack_above_stack_delta, stack_below_pack_thr, otp_written;
	logic otp_sleep_en, otp_storage_en, boot_seen;
	logic [15:0] accumulating_current_filter, fast_current_filter;
	logic [3:0] switch_request, src;
	logic [7:0] otp_storage_min;
	logic [31:0] d;
	logic [1:0] r;
	wire stack_below_sd, int_temp_high, die_overtemp;
	wire [4:0] cell_below_sd;
	wire [7:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp, mode;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire s_axi_rvalid, s_axi_rready, meas_current, meas_voltage, meas_temp;
	wire sleep_current_sample, comparator_prot_en, adc_prot_en, power_down;
	wire slow_oscillator_fast, auxiliary_regulator_en, boot_load_otp;
	wire boot_defaults, watchdog_reset, digital_reset, charge_switch;
	wire precharge_switch, discharge_switch, predischarge_switch;
	integer n_errors, samples_checked, cyc, waited, k, nc, nv;
	assign stack_below_sd = src[0];
	assign cell_below_sd = {4'h0, src[1]};
	assign int_temp_high = src[2];
	assign die_overtemp = src[3];
	bmpm_top #(.MS_CYCLES(MS)) bmpm_top_inst (.*);
	bmpm_host_model bmpm_host_model_inst (.*);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// sixteen timebase seconds of 5000 cycles, 80000 cycles in all
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (boot_defaults === 1'b1)
			boot_seen <= 1'b1;
		if (cyc == 80000) begin
			n_errors = n_errors + 1;
			tally_and_finish;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("wrong value at %0t: %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task wait_mode(input [1:0] m, input integer lim);
		begin
			waited = 0;
			while (mode !== m && waited < lim) begin
				@(posedge mclk);
				waited = waited + 1;
			end
			chk(mode, m);
		end
	endtask
	task hold(input [1:0] m, input integer n);
		integer bad;
		begin
			bad = 0;
			repeat (n) begin
				@(posedge mclk);
				if (mode !== m)
					bad = bad + 1;
			end
			chk(bad, 0);
		end
	endtask
	task wreg(input [7:0] a, input [31:0] v, input [1:0] er);
		begin
			bmpm_host_model_inst.wr(a, v, r);
			chk(r, er);
		end
	endtask
	task rreg(input [7:0] a, input [1:0] er);
		begin
			bmpm_host_model_inst.rd(a, d, r);
			chk(r, er);
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d, mismatches %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		{rst_n, cyc, n_errors, samples_checked, boot_seen, src} = 0;
		{rst_shut_pin, load_detect_above_wake, battery_below_por} = 0;
		{prot_fault, charger_detect, mem_error, otp_written} = 0;
		{pack_above_stack_delta, stack_below_pack_thr, otp_storage_en} = 0;
		{otp_storage_min, fast_current_filter} = 0;
		{wake_sense_pin, otp_sleep_en} = 2'b11;
		accumulating_current_filter = 16'h0100;
		switch_request = 4'hf;
		repeat (12) @(posedge mclk);
		chk(mode, `BMPM_MODE_SHUT);
		rst_n <= 1'b1;
		wait_mode(`BMPM_MODE_NORMAL, 100);
		chk(boot_seen, 1);
		rreg(`BMPM_REG_CFG, OK);
		chk(d, `BMPM_CFG_RST);
		rreg(`BMPM_REG_THR, OK);
		chk(d, `BMPM_THR_RST);
		rreg(`BMPM_REG_TIM0, OK);
		chk(d, `BMPM_TIM0_RST);
		rreg(`BMPM_REG_TIM1, OK);
		chk(d, `BMPM_TIM1_RST);
		rreg(8'h18, ERR);
		wreg(`BMPM_REG_STAT, 32'h0000_0001, ERR);
		rreg(`BMPM_REG_STAT, OK);
		chk(d[2], 1);
		{nc, nv} = 0;
		repeat (30 * MS) begin
			@(posedge mclk);
			nc = nc + (meas_current === 1'b1);
			nv = nv + (meas_voltage === 1'b1);
		end
		chk(nc, 10);
		chk(nv, 1);
		$display("test done: boot and normal schedule");
		wreg(`BMPM_REG_TIM0, 32'h0a00_0000, OK);
		wreg(`BMPM_REG_TIM1, 32'h0000_0a01, OK);
		wreg(`BMPM_REG_CMD, 32'h0000_0002, OK);
		repeat (2 * MS) @(posedge mclk);
		accumulating_current_filter <= 16'h0000;
		hold(`BMPM_MODE_NORMAL, 50);
		wreg(`BMPM_REG_CMD, 32'h0000_0001, OK);
		wait_mode(`BMPM_MODE_SLEEP, 100);
		rreg(`BMPM_REG_STAT, OK);
		chk(d[3:2], 2'b11);
		// each wake source but the accumulating filter in turn, rst_shut_pin last as it clears logic
		for (k = 0; k < 6; k = k + 1) begin
			wait_mode(`BMPM_MODE_SLEEP, 12000);
			case (k)
				0: fast_current_filter <= 16'h0080;
				1: prot_fault <= 1'b1;
				2: charger_detect <= 1'b1;
				3: {pack_above_stack_delta, stack_below_pack_thr} <= 2'b11;
				4: wreg(`BMPM_REG_CMD, 32'h0000_0020, OK);
				default: rst_shut_pin <= 1'b1;
			endcase
			if (k == 5) begin
				repeat (20) @(posedge mclk);
				rst_shut_pin <= 1'b0;
			end
			wait_mode(`BMPM_MODE_NORMAL, 12000);
			{prot_fault, charger_detect, fast_current_filter} <= 0;
			{pack_above_stack_delta, stack_below_pack_thr} <= 2'b00;
		end
		wreg(`BMPM_REG_TIM0, 32'h0a00_0002, OK);
		wait_mode(`BMPM_MODE_SLEEP, 12000);
		fast_current_filter <= 16'h0080;
		wait_mode(`BMPM_MODE_NORMAL, 200);
		fast_current_filter <= 16'h0000;
		hold(`BMPM_MODE_NORMAL, 4900);
		wait_mode(`BMPM_MODE_SLEEP, 6000);
		$display("test done: sleep entry and exit");
		accumulating_current_filter <= 16'h0100;
		wreg(`BMPM_REG_CMD, 32'h0000_0020, OK);
		wait_mode(`BMPM_MODE_NORMAL, 100);
		wreg(`BMPM_REG_CFG, 32'h0000_0001, OK);
		wreg(`BMPM_REG_CMD, 32'h0000_0004, OK);
		wait_mode(`BMPM_MODE_DEEP, 100);
		repeat (3) @(posedge mclk);
		chk({predischarge_switch, discharge_switch, precharge_switch,
			charge_switch}, 4'h0);
		chk(auxiliary_regulator_en, 1);
		wreg(`BMPM_REG_CMD, 32'h0000_0010, OK);
		hold(`BMPM_MODE_DEEP, 30);
		rreg(`BMPM_REG_STAT, OK);
		chk(d[4], 0);
		wreg(`BMPM_REG_CMD, 32'h0000_0008, OK);
		wait_mode(`BMPM_MODE_NORMAL, 4000);
		chk(waited >= 25 * MS * 10, 1);
		wreg(`BMPM_REG_CMD, 32'h0000_0004, OK);
		wait_mode(`BMPM_MODE_DEEP, 100);
		load_detect_above_wake <= 1'b1;
		wait_mode(`BMPM_MODE_NORMAL, 4000);
		load_detect_above_wake <= 1'b0;
		wreg(`BMPM_REG_CMD, 32'h0000_0004, OK);
		wait_mode(`BMPM_MODE_DEEP, 100);
		battery_below_por <= 1'b1;
		wait_mode(`BMPM_MODE_SHUT, 100);
		rreg(`BMPM_REG_STAT, ERR);
		chk(d, 0);
		battery_below_por <= 1'b0;
		boot_seen <= 1'b0;
		wake_sense_pin <= 1'b0;
		wait_mode(`BMPM_MODE_NORMAL, 200);
		wake_sense_pin <= 1'b1;
		chk(boot_seen, 1);
		rreg(`BMPM_REG_CFG, OK);
		chk(d, `BMPM_CFG_RST);
		$display("test done: deepsleep");
		wreg(`BMPM_REG_TIM0, 32'h0a00_0000, OK);
		load_detect_above_wake <= 1'b1;
		wreg(`BMPM_REG_CMD, 32'h0000_0010, OK);
		repeat (100) @(posedge mclk);
		chk(power_down, 0);
		load_detect_above_wake <= 1'b0;
		wait_mode(`BMPM_MODE_SHUT, 200);
		repeat (20) @(posedge mclk);
		chk(power_down, 1);
		load_detect_above_wake <= 1'b1;
		wait_mode(`BMPM_MODE_NORMAL, 200);
		load_detect_above_wake <= 1'b0;
		// stack, cell, temperature and die sources, each with its enable
		for (k = 0; k < 4; k = k + 1) begin
			wreg(`BMPM_REG_TIM0, 32'h0a00_0000, OK);
			wreg(`BMPM_REG_CFG, 32'h0000_0002 << k, OK);
			src <= 4'h1 << k;
			wait_mode(`BMPM_MODE_SHUT, 300);
			repeat (20) @(posedge mclk);
			chk(power_down, 1);
			src <= 4'h0;
			wake_sense_pin <= 1'b0;
			wait_mode(`BMPM_MODE_NORMAL, 200);
			wake_sense_pin <= 1'b1;
		end
		$display("test done: shutdown");
		tally_and_finish;
	end
endmodule
